// [rtl/cirpr_consts.svh]
`ifndef CIRPR_CONSTS_SVH
`define CIRPR_CONSTS_SVH

// register indexes; byte address on the bus is index * 4
`define CIRPR_IDX_COMMON_FLAGS 8'h15
`define CIRPR_IDX_SOCKET_MASK 8'h16
`define CIRPR_IDX_COMMON_MASK 8'h36
`define CIRPR_IDX_RETRY_PERIOD_HI 8'h17
`define CIRPR_IDX_RETRY_PERIOD_LO 8'h18
`define CIRPR_IDX_RETRY_LIMIT 8'h19
`define CIRPR_IDX_AUTH_TYPE_HI 8'h1c
`define CIRPR_IDX_AUTH_TYPE_LO 8'h1d
`define CIRPR_IDX_AUTH_ALGO 8'h1e
`define CIRPR_IDX_CHIP_REVISION 8'h1f
`define CIRPR_IDX_LCP_ECHO 8'h28
`define CIRPR_IDX_LCP_MAGIC 8'h29
`define CIRPR_IDX_REASSERT_HI 8'h30
`define CIRPR_IDX_REASSERT_LO 8'h31
`define CIRPR_IDX_SOCKET_SUMMARY 8'h34

// field positions
`define CIRPR_BIT_CONFLICT 7
`define CIRPR_BIT_PPPOE_CLOSE 5
`define CIRPR_COMMON_VALID_MASK 8'ha0

// reset values
`define CIRPR_RST_RETRY_PERIOD 16'h07d0
`define CIRPR_RST_RETRY_LIMIT 8'h08
`define CIRPR_RST_BYTE 8'h00
`define CIRPR_RST_WORD 16'h0000
`define CIRPR_AUTH_PAP 16'hc023
`define CIRPR_AUTH_CHAP 16'hc223
// arbitrary value, not a real part code
`define CIRPR_CHIP_REVISION 8'h5a

// timing
`define CIRPR_CLK_HZ 25000000
`define CIRPR_RETRY_UNIT_NS 100000
`define CIRPR_RETRY_UNIT_CYCLES ((`CIRPR_CLK_HZ / 1000000) * `CIRPR_RETRY_UNIT_NS / 1000)
`define CIRPR_INTERVAL_MAX 17'h0_ffff

`endif

// [rtl/cirpr_pkg.sv]
package cirpr_pkg;

  // kind of traffic the retry engine is timing
  typedef enum logic [1:0] {
    CIRPR_KIND_TCP,
    CIRPR_KIND_ARP,
    CIRPR_KIND_OTHER
  } cirpr_kind_t;

  // request to start timing an unanswered command or segment
  typedef struct packed {
    logic [2:0] socket;
    cirpr_kind_t kind;
  } cirpr_retry_req_t;

  // outcome pulses of the retry engine
  typedef struct packed {
    logic resend;
    logic timeout;
    logic set_closed;
    logic [2:0] socket;
  } cirpr_retry_evt_t;

  typedef enum {
    CIRPR_RETRY_IDLE,
    CIRPR_RETRY_WAIT
  } cirpr_retry_state_t;

endpackage : cirpr_pkg

// [rtl/cirpr_regs.sv]
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "cirpr_consts.svh"

// Overview of operation
// R1: mask bits 7 and 5 gate conflict and pppoe-close flags onto the interrupt pin.
// R2: retry period counts 100us units, resets to 0x07d0 for 200ms.
// R3: retry period high byte sits at the lower index, low byte above it.
// R4: unanswered or late connect, disconnect, close, send commands are retransmitted.
// R5: retry limit resets to 0x08; after limit resends the next expiry sets the timeout flag.
// R6: tcp final timeout also sets socket state closed in the same cycle.
// R7: arp request is resent after each silent retry period, limit times.
// R8: arp final timeout after period x 0.1ms x (limit+1) sets the timeout flag.
// R9: tcp segments wait one period for an ack, then are resent, limit times.
// R10: tcp interval doubles per resend while doubling stays within 65535.
// R11: read-only auth type reports c023 pap or c223 chap, resets to zero; here it reads ppp_auth_type_in directly, with no reset of its own.
// R12: read-only 8-bit chip revision at index 0x1f returns a fixed code.
// R13: lcp echo interval sets echo request spacing, about 25ms per count.
// R14: lcp magic number register feeds lcp negotiation, resets to zero.
// R15: 16-bit re-assert delay sets interrupt re-assert wait, resets to zero.
// R16: after a socket clear, re-assert after delay+1 clocks, one by default.
// R17: socket summary bit n sets whenever socket n raises any interrupt.
// R18: host clears socket flags to zero, summary bit then clears itself.
// R19: interrupt low while masked summary bits pend, released when all clear.
// R20: socket mask register at 0x16 masks summary bits, resets to zero.
// R21: conflict and pppoe-close flags set by events, cleared by writing one.
// R22: reserved common mask bits read zero and ignore writes.
module cirpr_regs import cirpr_pkg::*; (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // ahb-lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // protocol engine events
  input wire logic conflict_event_in,
  input wire logic pppoe_close_event_in,
  input wire logic [7:0] socket_event_in,
  input wire logic [7:0] socket_flags_cleared_in,
  input wire logic [15:0] ppp_auth_type_in,
  input wire logic [7:0] ppp_auth_algo_in,
  // retry engine
  input wire logic retry_start_in,
  input wire cirpr_retry_req_t retry_req_in,
  input wire logic retry_answered_in,
  output cirpr_retry_evt_t retry_evt_out,
  output logic [15:0] retry_interval_out,
  // pppoe settings
  output logic [7:0] lcp_echo_interval_out,
  output logic [7:0] lcp_magic_number_out,
  // interrupt pin
  output logic intr_out_n
);

  // ----------------------------------------
  // bus front end
  // ----------------------------------------
  localparam logic [15:0] TICK_CYCLES = 16'(`CIRPR_RETRY_UNIT_CYCLES);
  // one retry unit is 100us of the core clock; changing the clock rate
  // means changing the header, not this module

  logic wr_phase;
  logic rd_phase;
  logic rd_wait;
  logic [7:0] phase_idx;
  logic addr_take;
  logic [7:0] wr_byte;
  logic wr_en;

  // one slave on this bus, so hsel is honoured but nothing else is decoded;
  // hsize is ignored because every register sits in the low byte lane
  // trade-off: a read costs one extra cycle, a write none, which keeps the
  // read mux a registered stage instead of a long combinational path
  // from every register to the bus

  assign addr_take = hsel_in && hready_in && htrans_in[1];
  assign wr_byte = hwdata_in[7:0];
  assign wr_en = wr_phase;
  // reads take one wait state so that a write just before is seen
  assign hreadyout_out = !(rd_phase && rd_wait);
  assign hresp_out = 1'b0;


  // the phase registers only move when the slave is ready, so a stalled
  // read keeps its index until its data has been handed over
  // address phase capture
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      wr_phase <= 1'b0;
      rd_phase <= 1'b0;
      phase_idx <= 8'h00;
    end else if (hreadyout_out) begin
      wr_phase <= addr_take && hwrite_in;
      rd_phase <= addr_take && !hwrite_in;
      // aligned word per register; upper address bits beyond index ignored
      phase_idx <= haddr_in[9:2];
    end
  end

  // rd_wait starts high so the first cycle of every read data phase stalls
  // read wait-state flag
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rd_wait <= 1'b1;
    end else if (rd_phase) begin
      rd_wait <= !rd_wait;
    end else begin
      rd_wait <= 1'b1;
    end
  end

  // ----------------------------------------
  // software-written registers
  // ----------------------------------------
  logic [7:0] common_intr_mask;
  logic [7:0] socket_intr_mask;
  logic [15:0] retry_period;
  logic [7:0] retry_limit;
  logic [7:0] lcp_echo_interval;
  logic [7:0] lcp_magic_number;
  logic [15:0] intr_reassert_delay;

  // 16-bit registers are two independent bytes, high byte at the lower index;
  // software must write both halves, and the engines may see a half-updated
  // value between the two writes, which is accepted for these slow settings
  // read-only indexes fall into the default arm, so writes to them vanish

  // plain storage writes
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      common_intr_mask <= `CIRPR_RST_BYTE;
      socket_intr_mask <= `CIRPR_RST_BYTE; // R20
      retry_period <= `CIRPR_RST_RETRY_PERIOD; // R2
      retry_limit <= `CIRPR_RST_RETRY_LIMIT; // R5
      lcp_echo_interval <= `CIRPR_RST_BYTE;
      lcp_magic_number <= `CIRPR_RST_BYTE; // R14
      intr_reassert_delay <= `CIRPR_RST_WORD; // R15
    end else if (wr_en) begin
      unique case (phase_idx)
        `CIRPR_IDX_COMMON_MASK: common_intr_mask <= wr_byte & `CIRPR_COMMON_VALID_MASK; // R22
        `CIRPR_IDX_SOCKET_MASK: socket_intr_mask <= wr_byte; // R20
        `CIRPR_IDX_RETRY_PERIOD_HI: retry_period[15:8] <= wr_byte; // R3
        `CIRPR_IDX_RETRY_PERIOD_LO: retry_period[7:0] <= wr_byte; // R3
        `CIRPR_IDX_RETRY_LIMIT: retry_limit <= wr_byte;
        `CIRPR_IDX_LCP_ECHO: lcp_echo_interval <= wr_byte; // R13
        `CIRPR_IDX_LCP_MAGIC: lcp_magic_number <= wr_byte; // R14
        `CIRPR_IDX_REASSERT_HI: intr_reassert_delay[15:8] <= wr_byte; // R15
        `CIRPR_IDX_REASSERT_LO: intr_reassert_delay[7:0] <= wr_byte; // R15
        default: ;
      endcase
    end
  end

  // no shadowing: a new echo interval or magic number reaches the engine at once
  // pppoe settings go straight to the ppp engine
  assign lcp_echo_interval_out = lcp_echo_interval; // R13
  assign lcp_magic_number_out = lcp_magic_number; // R14

  // ----------------------------------------
  // interrupt flags
  // ----------------------------------------
  logic [7:0] common_intr_flags;
  logic [7:0] socket_intr_summary;
  logic [7:0] common_set;
  logic [7:0] common_w1c;
  logic [7:0] summary_w1c;
  logic [7:0] summary_set;

  // reserved flag bits are tied low at the source and again at the register
  assign common_set = {conflict_event_in, 1'b0, pppoe_close_event_in, 5'b0_0000};
  assign common_w1c = (wr_en && phase_idx == `CIRPR_IDX_COMMON_FLAGS) ? wr_byte : 8'h00;
  assign summary_w1c = (wr_en && phase_idx == `CIRPR_IDX_SOCKET_SUMMARY) ? wr_byte : 8'h00;

  // both flag registers give priority to a set over a clear in one cycle,
  // so an event that lands while the host clears is never lost
  // limitation: the summary only mirrors sockets; the per-socket flag
  // registers themselves live in the socket block, which reports the clear

  // a retry timeout is itself a socket interrupt
  always_comb begin
    summary_set = socket_event_in;
    if (retry_evt_out.timeout) begin
      summary_set[retry_evt_out.socket] = 1'b1;
    end
  end

  // common flags: an event in the clearing cycle survives
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      common_intr_flags <= `CIRPR_RST_BYTE;
    end else begin
      common_intr_flags <= ((common_intr_flags & ~common_w1c) | common_set) & `CIRPR_COMMON_VALID_MASK; // R21
    end
  end

  // the external clear pulse and a one written to the summary both empty a bit
  // socket summary: set on any socket event, cleared when host empties its flags
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      socket_intr_summary <= `CIRPR_RST_BYTE;
    end else begin
      socket_intr_summary <= (socket_intr_summary & ~socket_flags_cleared_in & ~summary_w1c)
        | summary_set; // R17 R18
    end
  end

  // ----------------------------------------
  // interrupt pin with re-assert wait
  // ----------------------------------------
  logic pending;
  logic socket_cleared;
  logic [16:0] wait_cnt;
  logic waiting;

  // common flags and socket summary feed the same pin, each through its own mask
  assign pending = |(common_intr_flags & common_intr_mask) // R1
    | |(socket_intr_summary & socket_intr_mask); // R19
  assign socket_cleared = |(socket_intr_summary & socket_flags_cleared_in);
  assign waiting = wait_cnt != 17'h0_0000;

  // after a clear the pin stays high for delay+1 clocks, so the host sees a fresh edge;
  // the clear cycle itself counts as the first of them, hence the load of delay alone
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      wait_cnt <= 17'h0_0000;
    end else if (socket_cleared) begin
      wait_cnt <= {1'b0, intr_reassert_delay}; // R16
    end else if (waiting) begin
      wait_cnt <= wait_cnt - 17'h0_0001;
    end
  end

  // the pin is a flop so it never glitches on decode of the summary bits
  // pin register, low while anything masked is pending
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      intr_out_n <= 1'b1;
    end else begin
      intr_out_n <= !(pending && !waiting && !socket_cleared); // R19 R16
    end
  end

  // ----------------------------------------
  // retry engine
  // ----------------------------------------
  cirpr_retry_state_t state;
  cirpr_retry_req_t active;
  logic [15:0] tick_cnt;
  logic [15:0] unit_cnt;
  logic [15:0] interval;
  logic [8:0] resends;
  logic tick;
  logic expire;
  logic [16:0] doubled;

  // tick marks the last cycle of each 100us unit
  assign tick = tick_cnt == TICK_CYCLES - 16'h0001;
  // a zero period still waits one unit
  assign expire = tick && (unit_cnt + 16'h0001 >= interval);
  assign doubled = {interval, 1'b0};
  assign retry_interval_out = interval;

  // one engine is shared by all sockets: a start that arrives while a wait
  // is running is ignored, and the socket block must hold its request
  // the unit counter is 16 bits, enough for the largest doubled interval;
  // doubling is checked one bit wider so an overflow can never wrap
  // limitation: a zero period is stretched to one unit rather than firing at once

  // 100us time base, restarted for each new wait
  always_ff @(posedge mclk_in) begin
    if (rst_in || state == CIRPR_RETRY_IDLE || tick) begin
      tick_cnt <= 16'h0000;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end

  // the timeout comes on the expiry after the last resend, so the whole wait
  // spans limit+1 periods; a tcp wait grows until doubling would overflow

  // timeout sequencing for arp requests, tcp segments and other commands
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state <= CIRPR_RETRY_IDLE;
      active <= '0;
      unit_cnt <= 16'h0000;
      interval <= 16'h0000;
      resends <= 9'h000;
      retry_evt_out <= '0;
    end else begin
      retry_evt_out <= '0;
      unique case (state)
        CIRPR_RETRY_IDLE: begin
          if (retry_start_in) begin // R4
            state <= CIRPR_RETRY_WAIT;
            active <= retry_req_in;
            interval <= retry_period; // R2
            unit_cnt <= 16'h0000;
            resends <= 9'h000;
          end
        end
        CIRPR_RETRY_WAIT: begin
          if (retry_answered_in) begin
            state <= CIRPR_RETRY_IDLE;
          end else if (expire) begin
            unit_cnt <= 16'h0000;
            if (resends == {1'b0, retry_limit}) begin // R5 R8
              state <= CIRPR_RETRY_IDLE;
              retry_evt_out.timeout <= 1'b1;
              retry_evt_out.set_closed <= active.kind == CIRPR_KIND_TCP; // R6
              retry_evt_out.socket <= active.socket;
            end else begin
              retry_evt_out.resend <= 1'b1; // R7 R9
              retry_evt_out.socket <= active.socket;
              resends <= resends + 9'h001;
              if (active.kind == CIRPR_KIND_TCP && doubled <= `CIRPR_INTERVAL_MAX) begin
                interval <= doubled[15:0]; // R10
              end
            end
          end else if (tick) begin
            unit_cnt <= unit_cnt + 16'h0001;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // read mux, loaded in the read wait state
  // ----------------------------------------
  // loading in the wait state rather than the address phase means a write
  // to the same index in the cycle before is already visible here
  // bits 31:8 always read zero; there is no error response for any index

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      hrdata_out <= 32'h0000_0000;
    end else if (rd_phase && rd_wait) begin
      hrdata_out <= 32'h0000_0000; // unmapped indexes read zero
      unique case (phase_idx)
        `CIRPR_IDX_COMMON_FLAGS: hrdata_out[7:0] <= common_intr_flags;
        `CIRPR_IDX_SOCKET_MASK: hrdata_out[7:0] <= socket_intr_mask;
        `CIRPR_IDX_COMMON_MASK: hrdata_out[7:0] <= common_intr_mask; // R22
        `CIRPR_IDX_RETRY_PERIOD_HI: hrdata_out[7:0] <= retry_period[15:8]; // R3
        `CIRPR_IDX_RETRY_PERIOD_LO: hrdata_out[7:0] <= retry_period[7:0]; // R3
        `CIRPR_IDX_RETRY_LIMIT: hrdata_out[7:0] <= retry_limit;
        `CIRPR_IDX_AUTH_TYPE_HI: hrdata_out[7:0] <= ppp_auth_type_in[15:8]; // R11
        `CIRPR_IDX_AUTH_TYPE_LO: hrdata_out[7:0] <= ppp_auth_type_in[7:0]; // R11
        `CIRPR_IDX_AUTH_ALGO: hrdata_out[7:0] <= ppp_auth_algo_in;
        `CIRPR_IDX_CHIP_REVISION: hrdata_out[7:0] <= `CIRPR_CHIP_REVISION; // R12
        `CIRPR_IDX_LCP_ECHO: hrdata_out[7:0] <= lcp_echo_interval;
        `CIRPR_IDX_LCP_MAGIC: hrdata_out[7:0] <= lcp_magic_number;
        `CIRPR_IDX_REASSERT_HI: hrdata_out[7:0] <= intr_reassert_delay[15:8];
        `CIRPR_IDX_REASSERT_LO: hrdata_out[7:0] <= intr_reassert_delay[7:0];
        `CIRPR_IDX_SOCKET_SUMMARY: hrdata_out[7:0] <= socket_intr_summary;
        default: ;
      endcase
    end
  end

endmodule : cirpr_regs

// [bench/cirpr_regs_sva.sv]
`timescale 1ns/1ps
// ----------------------------------------
// bus, register and retry checks
// ----------------------------------------
module cirpr_regs_sva import cirpr_pkg::*; (
  // clock, reset and bus
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  // engine side
  input wire logic [15:0] ppp_auth_type_in,
  input wire logic retry_start_in,
  input wire cirpr_retry_evt_t retry_evt_out,
  input wire logic [7:0] lcp_magic_number_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  localparam logic [31:0] REV = 32'h0000_005a; // arbitrary code, not a real part
  logic rd_p;
  logic wr_p;
  logic [7:0] idx;
  logic [15:0] gap;
  wire take = hsel_in && hready_in && htrans_in[1];
  wire rdv = rd_p && hreadyout_out;
  // pending data phase; idx only means something while one is pending
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rd_p <= 1'b0;
      wr_p <= 1'b0;
      idx <= 8'h00;
    end else if (hready_in) begin
      rd_p <= take && !hwrite_in;
      wr_p <= take && hwrite_in;
      idx <= haddr_in[9:2];
    end
  end
  // cycles since the last start or outcome, saturating so it never wraps
  always_ff @(posedge mclk_in) begin
    if (rst_in || retry_start_in || retry_evt_out.resend || retry_evt_out.timeout) begin
      gap <= 16'h0000;
    end else if (gap != 16'hffff) begin
      gap <= gap + 16'h0001;
    end
  end
  sequence s_rd_wait;
    !hreadyout_out ##1 hreadyout_out;
  endsequence
  a_read_wait:
    assert property (take && !hwrite_in |=> s_rd_wait) else $error("read wait state wrong");
  a_rev_fixed:
    assert property (rdv && idx == 8'h1f |-> hrdata_out == REV) else $error("revision read wrong");
  a_mask_rsvd:
    assert property (rdv && idx == 8'h36 |-> (hrdata_out & 32'hffff_ff5f) == 32'h0000_0000)
      else $error("reserved mask bits set");
  a_auth_high:
    assert property (rdv && idx == 8'h1c |-> hrdata_out[7:0] == ppp_auth_type_in[15:8])
      else $error("auth type read wrong");
  a_magic_hold:
    assert property (!$stable(lcp_magic_number_out) |-> $past(wr_p && hready_in && idx == 8'h29))
      else $error("magic number moved without a write");
  a_evt_pulse:
    assert property (retry_evt_out.resend |=> !retry_evt_out.resend && !retry_evt_out.timeout)
      else $error("resend not a lone pulse");
  a_closed_tmo:
    assert property (retry_evt_out.set_closed |-> retry_evt_out.timeout) else $error("closed without timeout");
  a_retry_gap:
    assert property (retry_evt_out.resend || retry_evt_out.timeout |-> gap >= 16'h09c2)
      else $error("retry outcome too early");
endmodule : cirpr_regs_sva

// [bench/cirpr_host_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// host controller on the register bus
// ----------------------------------------
module cirpr_host_model (
  // clock and answer
  input wire logic clk_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_in,
  // request
  output logic hsel_out,
  output logic [31:0] haddr_out,
  output logic [1:0] htrans_out,
  output logic hwrite_out,
  output logic [2:0] hsize_out,
  output logic [31:0] hwdata_out
);
  // idle bus at time zero
  initial begin
    hsel_out = 1'b1;
    haddr_out = 32'h0000_0000;
    htrans_out = 2'b00;
    hwrite_out = 1'b0;
    hsize_out = 3'b010;
    hwdata_out = 32'h0000_0000;
  end
  // single word transfer; hready and hrdata are taken at the rising edge that ends each phase
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rd);
    @(posedge clk_in);
    htrans_out <= 2'b10;
    hwrite_out <= wr;
    haddr_out <= {22'h00_0000, idx, 2'b00};
    do @(posedge clk_in); while (hready_in !== 1'b1);
    htrans_out <= 2'b00;
    hwdata_out <= {24'h00_0000, wd};
    do @(posedge clk_in); while (hready_in !== 1'b1);
    rd = hrdata_in;
  endtask : xfer
endmodule : cirpr_host_model

// [bench/test_cirpr_regs.sv]
`timescale 1ns/1ps
// ----------------------------------------
// register bank bench
// ----------------------------------------
module test_cirpr_regs import cirpr_pkg::*;;
  localparam logic [7:0] REV = 8'h5a; // arbitrary code, not a real part
  localparam logic [7:0] RI [16] = '{8'h17, 8'h18, 8'h19, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h28, 8'h29,
    8'h30, 8'h31, 8'h34, 8'h36, 8'h16, 8'h15, 8'h3f};
  localparam logic [7:0] RV [16] = '{8'h07, 8'hd0, 8'h08, 8'hc0, 8'h23, 8'h05, REV, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic conf = 1'b0, ppc = 1'b0, start = 1'b0, ans = 1'b0;
  logic hsel, hwrite, hready, hresp, intn;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] sev = 8'h00, scl = 8'h00, echo, magic, m;
  logic [15:0] auth = 16'hc023, ival;
  cirpr_retry_req_t req = '0;
  cirpr_retry_evt_t evt;
  int errors = 0, samples_checked = 0, h[2];
  cirpr_host_model i_cirpr_host_model (.clk_in(mclk_in), .hready_in(hready), .hrdata_in(hrdata),
    .hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize),
    .hwdata_out(hwdata));
  cirpr_regs i_cirpr_regs (.mclk_in(mclk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .conflict_event_in(conf),
    .pppoe_close_event_in(ppc), .socket_event_in(sev), .socket_flags_cleared_in(scl),
    .ppp_auth_type_in(auth), .ppp_auth_algo_in(8'h05), .retry_start_in(start), .retry_req_in(req),
    .retry_answered_in(ans), .retry_evt_out(evt), .retry_interval_out(ival),
    .lcp_echo_interval_out(echo), .lcp_magic_number_out(magic), .intr_out_n(intn));
  // 25 MHz clock
  initial begin
    forever #20 mclk_in = ~mclk_in;
  end
  // watchdog: the sequence needs about 23k cycles
  initial begin
    repeat (40000) @(posedge mclk_in);
    errors++;
    complete_run();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] x;
    i_cirpr_host_model.xfer(1'b1, idx, d, x);
  endtask : wr
  task automatic rc(input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] x;
    i_cirpr_host_model.xfer(1'b0, idx, 8'h00, x);
    chk(x, {24'h00_0000, e});
  endtask : rc
  task automatic nap(input int n);
    repeat (n) @(posedge mclk_in);
    @(negedge mclk_in);
  endtask : nap
  task automatic sock(input logic [7:0] ev, input logic [7:0] cl);
    @(posedge mclk_in);
    sev <= ev;
    scl <= cl;
    @(posedge mclk_in);
    sev <= 8'h00;
    scl <= 8'h00;
  endtask : sock
  // unit of 2500 cycles; arp total wait is period times (limit + 1), tcp doubles the period after each resend
  task automatic retry_run(input cirpr_kind_t k, input logic [2:0] s, input logic [7:0] lim);
    int cyc;
    int u;
    wr(8'h17, 8'h00);
    wr(8'h18, 8'h01);
    wr(8'h19, lim);
    @(posedge mclk_in);
    req <= '{socket: s, kind: k};
    start <= 1'b1;
    @(posedge mclk_in);
    start <= 1'b0;
    for (int n = 0; n <= lim; n++) begin
      u = (k == CIRPR_KIND_TCP) ? (1 << n) : 1;
      cyc = 0;
      do begin
        @(negedge mclk_in);
        cyc++;
      end while ((evt.resend | evt.timeout) !== 1'b1);
      chk(cyc > 2500 * u - 6 && cyc < 2500 * u + 6, 1'b1);
      chk({evt.resend, evt.timeout, evt.set_closed, evt.socket}, {n < lim, n == lim, n == lim && k == CIRPR_KIND_TCP, s});
      nap(2);
      if (n < lim) chk(ival, k == CIRPR_KIND_TCP ? 16'h0002 << n : 16'h0001);
    end
    rc(8'h34, 8'h01 << s);
    sock(8'h00, 8'h01 << s);
  endtask : retry_run
  task automatic complete_run();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  // main sequence
  initial begin
    repeat (12) @(posedge mclk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 16; i++) rc(RI[i], RV[i]);
    auth <= 16'hc223;
    rc(8'h1c, 8'hc2);
    chk(hresp, 1'b0);
    wr(8'h36, 8'hff);
    rc(8'h36, 8'ha0);
    wr(8'h36, 8'h00);
    wr(8'h1f, 8'h00);
    rc(8'h1f, REV);
    wr(8'h17, 8'h0f);
    wr(8'h18, 8'ha0);
    rc(8'h17, 8'h0f);
    rc(8'h18, 8'ha0);
    wr(8'h28, 8'hc8);
    wr(8'h29, 8'h3c);
    nap(1);
    chk(echo, 8'hc8);
    chk(magic, 8'h3c);
    // common flags: silent while masked, pin follows the mask, write one clears
    for (int k = 0; k < 2; k++) begin
      m = k ? 8'h20 : 8'h80;
      @(posedge mclk_in);
      conf <= (k == 0);
      ppc <= (k == 1);
      @(posedge mclk_in);
      conf <= 1'b0;
      ppc <= 1'b0;
      nap(3);
      chk(intn, 1'b1);
      rc(8'h15, m);
      wr(8'h36, m);
      nap(3);
      chk(intn, 1'b0);
      wr(8'h15, m);
      nap(3);
      chk(intn, 1'b1);
      wr(8'h36, 8'h00);
    end
    // two sockets pending; clearing one re-asserts after the delay
    wr(8'h16, 8'h03);
    for (int k = 0; k < 2; k++) begin
      wr(8'h31, k ? 8'h0f : 8'h00);
      sock(8'h03, 8'h00);
      nap(2);
      chk(intn, 1'b0);
      rc(8'h34, 8'h03);
      sock(8'h00, 8'h01);
      h[k] = 0;
      repeat (40) begin
        @(negedge mclk_in);
        if (intn === 1'b1) h[k]++;
      end
      chk(intn, 1'b0);
      rc(8'h34, 8'h02);
      sock(8'h04, 8'h02);
      nap(20);
      chk(intn, 1'b1);
      rc(8'h34, 8'h04);
      sock(8'h00, 8'h04);
    end
    chk(h[1] - h[0], 15);
    chk(h[0], 1);
    retry_run(CIRPR_KIND_TCP, 3'd3, 8'h02);
    retry_run(CIRPR_KIND_ARP, 3'd5, 8'h01);
    complete_run();
  end
endmodule : test_cirpr_regs
bind cirpr_regs cirpr_regs_sva i_cirpr_regs_sva (.mclk_in(mclk_in), .rst_in(rst_in), .hsel_in(hsel_in),
  .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in),
  .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .ppp_auth_type_in(ppp_auth_type_in),
  .retry_start_in(retry_start_in), .retry_evt_out(retry_evt_out), .lcp_magic_number_out(lcp_magic_number_out));
